// *** src/emhf_framer.sv ***
/*
  event message housekeeping framer: command check counting, rejection
  messages, essential housekeeping block with eight-slot event extension,
  apb register slave.
  assumes a synchronous command checker upstream and a byte sink that
  takes hk_byte_out on hk_valid_out and hk_ready_in.
*/
// Implementation choices: the placing of the registers and the APB register port.
// Notes on behaviour
// - passing command executes, executed counter increments
// - failing command: discard, count, queue message (dropped, counted only, when the 16-entry queue is full)
// - messages appended after standard housekeeping data
// - exactly eight slots per block
// - slot is three 16-bit words
// - length byte (n+50)/2, then command code
// - valid counter two bytes, then slots
// - counter position follows standard length n
// - empty slots carry identifier 255
// - carried messages deleted after readout
// - word one top six bits: source
// - next two bits: message class
// - identifier stays within 128 to 254
// - identifier upper bits from allocated range
// - low three identifier bits give reason
// - body: command code, apid, sequence control
// - sequence bits zero, zero, origin
`timescale 1ns/100ps
`default_nettype none
`include "emhf_cfg.svh"
module emhf_framer
  import emhf_pkg::*;
#(
  parameter int DEPTH = 16,
  parameter int CNT_W = 16
) (
  input  wire logic        clk_in,
  input  wire logic        reset_n_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output var  logic [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  input  wire logic        cmd_valid_in,
  input  wire emhf_cmd_s   cmd_in,
  output var  logic        cmd_exec_out,
  input  wire logic        hk_start_in,
  input  wire logic [7:0]  std_byte_in,
  output logic             std_take_out,
  output var  logic [7:0]  hk_byte_out,
  output var  logic        hk_valid_out,
  input  wire logic        hk_ready_in,
  output logic             busy_out
);
  localparam int PW = $clog2(DEPTH);
  function automatic logic [7:0] slot_byte(input emhf_msg_s m, input logic [2:0] off);
    case (off)
      3'h0:    slot_byte = {m.src, m.cls};
      3'h1:    slot_byte = m.id;
      3'h2:    slot_byte = m.code;
      3'h3:    slot_byte = m.apid;
      3'h4:    slot_byte = m.psc[15:8];
      default: slot_byte = m.psc[7:0];
    endcase
  endfunction : slot_byte
  logic [5:0]       src_q;
  logic [1:0]       cls_q;
  logic [4:0]       idup_q;
  logic [7:0]       stdlen_q;
  logic [7:0]       hkcode_q;
  logic [CNT_W-1:0] exec_q;
  logic [CNT_W-1:0] rej_q;
  logic [PW:0]      count_q;
  logic [PW-1:0]    rd_q;
  logic [PW-1:0]    wr_q;
  logic [3:0]       snap_q;
  emhf_state_e      state_q;
  logic [7:0]       pos_q;
  logic [2:0]       slot_q;
  logic [2:0]       off_q;
  emhf_msg_s        mem_q [DEPTH];
  wire setup_rd  = psel_in & ~penable_in & ~pwrite_in;
  wire access    = psel_in & penable_in;
  wire wr_en     = access & pwrite_in;
  wire hit_ctrl  = paddr_in == `EMHF_OFF_CTRL;
  wire hit_hkcfg = paddr_in == `EMHF_OFF_HKCFG;
  wire hit_exec  = paddr_in == `EMHF_OFF_EXEC;
  wire hit_rej   = paddr_in == `EMHF_OFF_REJ;
  wire hit_stat  = paddr_in == `EMHF_OFF_STAT;
  wire mapped    = hit_ctrl | hit_hkcfg | hit_exec | hit_rej | hit_stat;
  wire ro_hit    = hit_exec | hit_rej | hit_stat;
  assign pready_out  = 1'b1;
  assign pslverr_out = access & (~mapped | (pwrite_in & ro_hit));
  wire [31:0] rd_word =
    hit_ctrl  ? {19'h0, idup_q, cls_q, src_q} :
    hit_hkcfg ? {16'h0, hkcode_q, stdlen_q} :
    hit_exec  ? 32'(exec_q) :
    hit_rej   ? 32'(rej_q) :
    hit_stat  ? {23'h0, busy_out, 3'h0, 5'(count_q)} : 32'h0;
  wire cmd_ok  = cmd_valid_in & cmd_in.ok;
  wire cmd_bad = cmd_valid_in & ~cmd_in.ok;
  wire full    = count_q == (PW + 1)'(DEPTH);
  wire push    = cmd_bad & ~full;
  wire [7:0] raw_id = {1'b1, idup_q[3:0], cmd_in.reason};
  emhf_msg_s new_msg;
  assign new_msg.src  = src_q;
  assign new_msg.cls  = cls_q;
  assign new_msg.id   = (raw_id == `EMHF_EMPTY_ID) ? `EMHF_MAX_ID : raw_id;
  assign new_msg.code = cmd_in.code;
  assign new_msg.apid = cmd_in.apid;
  assign new_msg.psc  = {2'b00, cmd_in.onboard, cmd_in.psc[12:0]};
  wire advance  = ~hk_valid_out | hk_ready_in;
  wire last_std = pos_q == stdlen_q;
  wire last_out = (state_q == ST_SLOT) & (slot_q == `EMHF_LAST_SLOT)
                  & (off_q == `EMHF_LAST_OFF) & advance;
  wire pop      = last_out;
  wire start    = (state_q == ST_IDLE) & hk_start_in;
  wire [8:0] len_sum = 9'(stdlen_q) + `EMHF_EXT_BYTES;
  wire [3:0] pend_lim = (count_q > (PW + 1)'(`EMHF_SLOTS)) ? `EMHF_SLOTS : 4'(count_q);
  wire slot_full = 4'(slot_q) < snap_q;
  emhf_msg_s slot_msg;
  emhf_msg_s empty_msg;
  assign slot_msg  = mem_q[PW'(rd_q + PW'(slot_q))];
  assign empty_msg = '{src: src_q, cls: cls_q, id: `EMHF_EMPTY_ID, default: '0};
  assign busy_out  = state_q != ST_IDLE;
  assign std_take_out = (state_q == ST_STD) & advance;
  logic [7:0]  cur_byte;
  emhf_state_e state_d;
  always_comb begin
    cur_byte = 8'h00;
    state_d  = state_q;
    case (state_q)
      ST_IDLE: begin
        if (hk_start_in) begin
          state_d = ST_LEN;
        end
      end
      ST_LEN: begin
        cur_byte = len_sum[8:1];
        state_d  = ST_CID;
      end
      ST_CID: begin
        cur_byte = hkcode_q;
        state_d  = (stdlen_q < `EMHF_FIRST_STD) ? ST_CNT_HI : ST_STD;
      end
      ST_STD: begin
        cur_byte = std_byte_in;
        state_d  = last_std ? ST_CNT_HI : ST_STD;
      end
      ST_CNT_HI: begin
        state_d = ST_CNT_LO;
      end
      ST_CNT_LO: begin
        cur_byte = 8'(snap_q);
        state_d  = ST_SLOT;
      end
      ST_SLOT: begin
        cur_byte = slot_byte(slot_full ? slot_msg : empty_msg, off_q);
        if ((slot_q == `EMHF_LAST_SLOT) && (off_q == `EMHF_LAST_OFF)) begin
          state_d = ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      src_q      <= `EMHF_SRC_RST;
      cls_q      <= `EMHF_CLASS_RST;
      idup_q     <= `EMHF_IDUP_RST;
      stdlen_q   <= `EMHF_STDLEN_RST;
      hkcode_q   <= `EMHF_HKCODE_RST;
      prdata_out <= 32'h0;
    end else begin
      if (setup_rd) begin
        prdata_out <= rd_word;
      end
      if (wr_en && hit_ctrl) begin
        src_q  <= pwdata_in[5:0];
        cls_q  <= pwdata_in[7:6];
        idup_q <= pwdata_in[12:8];
      end
      if (wr_en && hit_hkcfg) begin
        stdlen_q <= pwdata_in[7:0];
        hkcode_q <= pwdata_in[15:8];
      end
    end
  end
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      exec_q       <= '0;
      rej_q        <= '0;
      cmd_exec_out <= 1'b0;
    end else begin
      cmd_exec_out <= cmd_ok;
      exec_q <= exec_q + CNT_W'(cmd_ok);
      rej_q <= rej_q + CNT_W'(cmd_bad);
    end
  end
  always_ff @(posedge clk_in) begin
    if (push) begin
      mem_q[wr_q] <= new_msg;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wr_q    <= '0;
      rd_q    <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + PW'(1);
      end
      if (pop) begin
        rd_q <= PW'(rd_q + PW'(snap_q));
      end
      count_q <= count_q + (PW + 1)'(push) - (pop ? (PW + 1)'(snap_q) : '0);
    end
  end
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_q      <= ST_IDLE;
      pos_q        <= '0;
      slot_q       <= '0;
      off_q        <= '0;
      snap_q       <= '0;
      hk_byte_out  <= 8'h00;
      hk_valid_out <= 1'b0;
    end else begin
      if (start) begin
        snap_q <= pend_lim;
        pos_q  <= `EMHF_FIRST_STD;
        slot_q <= '0;
        off_q  <= '0;
      end
      if (advance && state_q != ST_IDLE) begin
        state_q      <= state_d;
        hk_byte_out  <= cur_byte;
        hk_valid_out <= 1'b1;
        if (state_q == ST_STD) begin
          pos_q <= pos_q + 8'h01;
        end
        // six bytes per slot, eight slots
        if (state_q == ST_SLOT) begin
          off_q <= (off_q == `EMHF_LAST_OFF) ? 3'h0 : off_q + 3'h1;
          if (off_q == `EMHF_LAST_OFF) begin
            slot_q <= slot_q + 3'h1;
          end
        end
      end else if (state_q == ST_IDLE) begin
        state_q <= state_d;
        if (hk_ready_in) begin
          hk_valid_out <= 1'b0;
        end
      end
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  logic [8:0] sent_q;
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sent_q <= '0;
    end else if (start) begin
      sent_q <= '0;
    end else if (advance && busy_out) begin
      sent_q <= sent_q + 9'h001;
    end
  end

  sequence block_begin;
    start ##1 (state_q == ST_LEN && advance);
  endsequence
  exec_count_a: assert property (cmd_ok |=> exec_q == $past(exec_q) + CNT_W'(1))
    else $error("executed count did not step");
  reject_queue_a: assert property (push && !pop |=> rej_q == $past(rej_q) + CNT_W'(1)
    && count_q == $past(count_q) + (PW + 1)'(1))
    else $error("rejection not counted or queued");
  len_byte_a: assert property (block_begin |=> hk_valid_out
    && hk_byte_out == 8'((9'($past(stdlen_q)) + `EMHF_EXT_BYTES) >> 1))
    else $error("length byte wrong");
  block_len_a: assert property (last_out |-> sent_q + 9'h001 == len_sum)
    else $error("block length not n+50");
  count_byte_a: assert property (state_q == ST_CNT_LO && advance
    |=> hk_byte_out == 8'(snap_q))
    else $error("event counter byte wrong");
  empty_id_a: assert property (state_q == ST_SLOT && advance && !slot_full && off_q == 3'h1
    |=> hk_byte_out == `EMHF_EMPTY_ID)
    else $error("empty slot not marked 255");
  delete_msgs_a: assert property (pop && !push
    |=> count_q == $past(count_q) - (PW + 1)'($past(snap_q)))
    else $error("carried messages not deleted");
  id_range_a: assert property (push |-> new_msg.id >= 8'h80 && new_msg.id <= `EMHF_MAX_ID)
    else $error("identifier out of range");
  psc_bits_a: assert property (push |-> new_msg.psc[15:14] == 2'b00
    && new_msg.psc[13] == cmd_in.onboard)
    else $error("sequence control bits wrong");
  slot_limit_a: assert property (start |=> snap_q <= `EMHF_SLOTS)
    else $error("more than eight messages");
endmodule : emhf_framer
`default_nettype wire

// *** shared/emhf_cfg.svh ***
/*
  constants of the event message housekeeping framer: register offsets,
  reset values, frame layout figures.
  assumes inclusion by bare name from the package and the design.
*/
`ifndef EMHF_CFG_SVH
`define EMHF_CFG_SVH

`define EMHF_OFF_CTRL      8'h00
`define EMHF_OFF_HKCFG     8'h04
`define EMHF_OFF_EXEC      8'h08
`define EMHF_OFF_REJ       8'h0c
`define EMHF_OFF_STAT      8'h10

`define EMHF_SRC_RST       6'h20
`define EMHF_CLASS_RST     2'h3
`define EMHF_IDUP_RST      5'h13
`define EMHF_STDLEN_RST    8'h22
`define EMHF_HKCODE_RST    8'h00

`define EMHF_SLOTS         4'h8
`define EMHF_LAST_SLOT     3'h7
`define EMHF_LAST_OFF      3'h5
`define EMHF_EXT_BYTES     9'h032
`define EMHF_EMPTY_ID      8'hff
`define EMHF_MAX_ID        8'hfe
`define EMHF_FIRST_STD     8'h03

`endif

// *** shared/emhf_pkg.sv ***
/*
  types of the event message housekeeping framer.
  assumes emhf_cfg.svh is on the include path.
*/
`default_nettype none
package emhf_pkg;
  `include "emhf_cfg.svh"

  typedef struct packed {
    logic        ok;
    logic [2:0]  reason;
    logic [7:0]  code;
    logic [7:0]  apid;
    logic [15:0] psc;
    logic        onboard;
  } emhf_cmd_s;

  typedef struct packed {
    logic [5:0]  src;
    logic [1:0]  cls;
    logic [7:0]  id;
    logic [7:0]  code;
    logic [7:0]  apid;
    logic [15:0] psc;
  } emhf_msg_s;

  typedef enum logic [2:0] {
    ST_IDLE, ST_LEN, ST_CID, ST_STD, ST_CNT_HI, ST_CNT_LO, ST_SLOT
  } emhf_state_e;
endpackage : emhf_pkg
`default_nettype wire

// *** dv/emhf_partner.sv ***
/*
  far side model: processing unit byte sink with stalls, and the source
  of standard housekeeping bytes.
  assumes the framer's hk and std ports on one clock.
*/
`timescale 1ns/100ps
`default_nettype none
module emhf_partner (
  input  wire logic       clk_in,
  input  wire logic       reset_n_in,
  input  wire logic [7:0] hk_byte_in,
  input  wire logic       hk_valid_in,
  output logic            hk_ready_out,
  input  wire logic       std_take_in,
  output logic [7:0]      std_byte_out
);
  logic [7:0] got[$];
  logic [1:0] tick_q;
  logic [7:0] std_idx_q;
  assign std_byte_out = std_idx_q ^ 8'h5a;
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tick_q <= 2'h0;
      hk_ready_out <= 1'b0;
      std_idx_q <= 8'h00;
    end else begin
      tick_q <= tick_q + 2'h1;
      hk_ready_out <= (tick_q != 2'h3);
      if (std_take_in) begin
        std_idx_q <= std_idx_q + 8'h01;
      end
    end
  end
  always @(posedge clk_in) begin
    if (hk_valid_in && hk_ready_out) begin
      got.push_back(hk_byte_in);
    end
  end
endmodule : emhf_partner
`default_nettype wire

// *** dv/tb_top.sv ***
/*
  testbench of the event message housekeeping framer: apb access,
  command results, housekeeping blocks checked byte by byte.
  assumes the framer, its package and the partner model.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import emhf_pkg::*;
  logic        clk_in = 1'b0;
  logic        reset_n_in = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        cmd_valid = 1'b0;
  emhf_cmd_s   cmd = '0;
  logic        cmd_exec;
  logic        hk_start = 1'b0;
  logic [7:0]  std_byte;
  logic        std_take;
  logic [7:0]  hk_byte;
  logic        hk_valid;
  logic        hk_ready;
  logic        busy;
  logic [47:0] mq[$];
  logic [7:0]  hi = 8'h83;
  logic [4:0]  idup = 5'h13;
  logic [2:0]  rs[4] = '{3'h0, 3'h1, 3'h5, 3'h6};
  int          num_errors = 0;
  int          n_checks = 0;
  int          cyc = 0;
  int          held = 0;

  emhf_framer u_emhf_framer (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .cmd_valid_in(cmd_valid), .cmd_in(cmd),
    .cmd_exec_out(cmd_exec), .hk_start_in(hk_start), .std_byte_in(std_byte),
    .std_take_out(std_take), .hk_byte_out(hk_byte), .hk_valid_out(hk_valid),
    .hk_ready_in(hk_ready), .busy_out(busy));
  emhf_partner u_emhf_partner (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .hk_byte_in(hk_byte),
    .hk_valid_in(hk_valid), .hk_ready_out(hk_ready), .std_take_in(std_take),
    .std_byte_out(std_byte));

  always #25 clk_in = ~clk_in;

  task automatic summarize();
    if (num_errors == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : summarize

  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      num_errors++;
      summarize();
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     input logic [31:0] exp, input logic experr);
    @(posedge clk_in);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_in);
    penable <= 1'b1;
    do @(posedge clk_in); while (pready !== 1'b1);
    if (!wr) check("prdata", prdata, exp);
    check("pslverr", {31'h0, pslverr}, {31'h0, experr});
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic send(input logic ok, input logic [2:0] r, input logic [7:0] i);
    logic [7:0] id;
    @(posedge clk_in);
    cmd_valid <= 1'b1;
    cmd <= {ok, r, 8'h10 + i, 8'h40 + i, 16'hffff, i[0]};
    @(posedge clk_in);
    cmd_valid <= 1'b0;
    #1;
    check("exec", {31'h0, cmd_exec}, {31'h0, ok});
    id = ({1'b1, idup[3:0], r} == 8'hff) ? 8'hfe : {1'b1, idup[3:0], r};
    if (!ok) mq.push_back({hi, id, 8'h10 + i, 8'h40 + i, 2'b00, i[0], 13'h1fff});
  endtask : send

  task automatic block(input int n, input logic [7:0] code);
    logic [7:0]  e[$];
    logic [47:0] m;
    logic [7:0]  base;
    int          cnt;
    cnt = (mq.size() > 8) ? 8 : mq.size();
    base = u_emhf_partner.std_idx_q;
    u_emhf_partner.got.delete();
    e.push_back(8'((n + 50) / 2));
    e.push_back(code);
    for (int j = 0; j < n - 2; j++) e.push_back(8'(base + j) ^ 8'h5a);
    e.push_back(8'h00);
    e.push_back(8'(cnt));
    for (int s = 0; s < 8; s++) begin
      m = (s < cnt) ? mq.pop_front() : {hi, 40'hff00000000};
      for (int b = 5; b >= 0; b--) e.push_back(m[b*8 +: 8]);
    end
    @(posedge clk_in);
    hk_start <= 1'b1;
    @(posedge clk_in);
    hk_start <= 1'b0;
    #1;
    check("busy", {31'h0, busy}, 32'h1);
    for (int t = 0; t < 400 && u_emhf_partner.got.size() < n + 50; t++) @(posedge clk_in);
    repeat (4) @(posedge clk_in);
    check("hk size", u_emhf_partner.got.size(), n + 50);
    for (int j = 0; j < n + 50; j++) begin
      check("hk byte", u_emhf_partner.got[j], e[j]);
    end
    // cpu buffer holds 64, full drops
    held = (held + cnt > 64) ? 64 : held + cnt;
  endtask : block

  initial begin
    repeat (8) @(posedge clk_in);
    reset_n_in <= 1'b1;
    apb(1'b0, 8'h00, 32'h0, 32'h13e0, 1'b0);
    apb(1'b0, 8'h04, 32'h0, 32'h22, 1'b0);
    apb(1'b0, 8'h14, 32'h0, 32'h0, 1'b1);
    apb(1'b1, 8'h08, 32'h5, 32'h0, 1'b1);
    block(34, 8'h00);
    send(1'b1, 3'h0, 8'h00);
    for (int i = 0; i < 9; i++) send(1'b0, rs[i % 4], 8'(i));
    apb(1'b0, 8'h08, 32'h0, 32'h1, 1'b0);
    apb(1'b0, 8'h0c, 32'h0, 32'h9, 1'b0);
    apb(1'b0, 8'h10, 32'h0, 32'h9, 1'b0);
    apb(1'b1, 8'h04, 32'h5a0c, 32'h0, 1'b0);
    block(12, 8'h5a);
    block(12, 8'h5a);
    block(12, 8'h5a);
    apb(1'b1, 8'h00, 32'h18f8, 32'h0, 1'b0);
    hi = 8'he3;
    idup = 5'h18;
    send(1'b0, 3'h6, 8'h01);
    block(12, 8'h5a);
    apb(1'b1, 8'h00, 32'h1ff8, 32'h0, 1'b0);
    idup = 5'h1f;
    send(1'b0, 3'h7, 8'h02);
    block(12, 8'h5a);
    summarize();
  end
endmodule : tb_top
`default_nettype wire
